// file: spi_prescale_pkg.sv
package spi_prescale_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ATTR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int AT_PRESC_LSB = 18;
  localparam int BAUD_PRESC_LSB = 16;
  localparam int AT_SCALER_LSB = 4;
  localparam int BAUD_SCALER_LSB = 0;
  localparam int CTRL_MASTER_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_GAP_BIT = 1;
  localparam int ST_PEND_BIT = 2;
  localparam int ST_MASTER_BIT = 3;
  localparam int ST_BAUD_DIV_LSB = 8;
  localparam int ST_AT_DIV_LSB = 12;
  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [31:0] ATTR_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int FRAME_EDGES = 16;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] atPresc;
    logic [1:0] baudPresc;
    logic [3:0] atScaler;
    logic [3:0] baudScaler;
  } timing_cfg_t;
  typedef struct packed {
    logic sck;
    logic sckOe;
    logic pcsN;
    logic pcsOe;
  } spi_pins_t;
  // ----------------------------------------
  // prescaler decode
  // ----------------------------------------
  function automatic logic [2:0] at_prescale_value(input logic [1:0] code);
    case (code)
      2'h0: at_prescale_value = 3'h1;
      2'h1: at_prescale_value = 3'h3;
      2'h2: at_prescale_value = 3'h5;
      default: at_prescale_value = 3'h7;
    endcase
  endfunction
  function automatic logic [2:0] baud_prescale_value(input logic [1:0] code);
    case (code)
      2'h0: baud_prescale_value = 3'h2;
      2'h1: baud_prescale_value = 3'h3;
      2'h2: baud_prescale_value = 3'h5;
      default: baud_prescale_value = 3'h7;
    endcase
  endfunction
endpackage

// ----------------------------------------
// prescale divider: one tick every divisor cycles
// ----------------------------------------
module prescale_divider #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic run,
  input wire logic [WIDTH-1:0] divisor,
  // result
  output logic tick
);
  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  if (WIDTH < 1) begin
    $error("divider width must be at least 1");
  end

  always_comb begin
    nxt_cnt = '0;
    nxt_tick = 1'b0;
    if (run) begin
      if (cnt_ff >= divisor - WIDTH'(1)) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule

// file: spi_clock_delay.sv
// Operation
// - the after-transfer prescale field sets the prescaler of the chip-select idle gap.
// - the after-transfer prescale is used only as master and ignored as slave.
// - after-transfer prescale codes 00, 01, 10, 11 give 1, 3, 5, 7.
// - the baud prescale field selects the prescaler for the serial clock rate.
// - the baud prescale is used only as master; as slave no serial clock is made.
// - the bus clock is divided by the baud prescaler first, then by the baud scaler.
// - baud prescale codes 00, 01, 10 give divide by 2, 3, 5.
module spi_clock_delay (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  output logic sck,
  output logic sckOe,
  output logic pcsN,
  output logic pcsOe
);
  typedef enum logic [1:0] {IDLE, SHIFT, GAP} state_t;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  state_t st_ff;
  state_t nxt_st;
  logic [31:0] attr_ff;
  logic [31:0] nxt_attr;
  logic master_ff;
  logic nxt_master;
  logic pend_ff;
  logic nxt_pend;
  logic [3:0] scCnt_ff;
  logic [3:0] nxt_scCnt;
  logic [4:0] edgeCnt_ff;
  logic [4:0] nxt_edgeCnt;
  spi_prescale_pkg::spi_pins_t pins_ff;
  spi_prescale_pkg::spi_pins_t nxt_pins;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;

  spi_prescale_pkg::timing_cfg_t cfg;
  logic [2:0] baudDiv;
  logic [2:0] atDiv;
  logic baudTick;
  logic gapTick;
  logic wrAccess;
  logic setupPhase;
  logic mapped;
  logic startWrite;

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  always_comb begin
    cfg.atPresc = attr_ff[spi_prescale_pkg::AT_PRESC_LSB +: 2];
    cfg.baudPresc = attr_ff[spi_prescale_pkg::BAUD_PRESC_LSB +: 2];
    cfg.atScaler = attr_ff[spi_prescale_pkg::AT_SCALER_LSB +: 4];
    cfg.baudScaler = attr_ff[spi_prescale_pkg::BAUD_SCALER_LSB +: 4];
    atDiv = spi_prescale_pkg::at_prescale_value(cfg.atPresc);
    baudDiv = spi_prescale_pkg::baud_prescale_value(cfg.baudPresc);
  end

  // ----------------------------------------
  // prescalers
  // ----------------------------------------
  prescale_divider #(.WIDTH(3)) u_baud_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(st_ff == SHIFT && master_ff),
    .divisor(baudDiv),
    .tick(baudTick)
  );

  prescale_divider #(.WIDTH(3)) u_gap_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(st_ff == GAP && master_ff),
    .divisor(atDiv),
    .tick(gapTick)
  );

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign setupPhase = psel && !penable;
  assign wrAccess = psel && penable && pwrite && pready_ff;
  assign startWrite = wrAccess && paddr == spi_prescale_pkg::OFS_CTRL
    && pwdata[spi_prescale_pkg::CTRL_START_BIT];

  always_comb begin
    mapped = paddr == spi_prescale_pkg::OFS_CTRL || paddr == spi_prescale_pkg::OFS_ATTR
      || paddr == spi_prescale_pkg::OFS_STATUS;
    nxt_pready = setupPhase;
    nxt_pslverr = setupPhase && !mapped;
    nxt_prdata = prdata_ff;
    if (setupPhase) begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
        spi_prescale_pkg::OFS_CTRL: nxt_prdata[spi_prescale_pkg::CTRL_MASTER_BIT] = master_ff;
        spi_prescale_pkg::OFS_ATTR: nxt_prdata = attr_ff;
        spi_prescale_pkg::OFS_STATUS: begin
          nxt_prdata[spi_prescale_pkg::ST_BUSY_BIT] = st_ff != IDLE;
          nxt_prdata[spi_prescale_pkg::ST_GAP_BIT] = st_ff == GAP;
          nxt_prdata[spi_prescale_pkg::ST_PEND_BIT] = pend_ff;
          nxt_prdata[spi_prescale_pkg::ST_MASTER_BIT] = master_ff;
          nxt_prdata[spi_prescale_pkg::ST_BAUD_DIV_LSB +: 3] = baudDiv;
          nxt_prdata[spi_prescale_pkg::ST_AT_DIV_LSB +: 3] = atDiv;
        end
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
    nxt_attr = attr_ff;
    nxt_master = master_ff;
    if (wrAccess && paddr == spi_prescale_pkg::OFS_ATTR) begin
      nxt_attr = pwdata;
    end
    if (wrAccess && paddr == spi_prescale_pkg::OFS_CTRL) begin
      nxt_master = pwdata[spi_prescale_pkg::CTRL_MASTER_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      attr_ff <= spi_prescale_pkg::ATTR_RESET;
      master_ff <= spi_prescale_pkg::CTRL_RESET[spi_prescale_pkg::CTRL_MASTER_BIT];
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      attr_ff <= nxt_attr;
      master_ff <= nxt_master;
    end
  end

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_scCnt = scCnt_ff;
    nxt_edgeCnt = edgeCnt_ff;
    nxt_pend = pend_ff;
    case (st_ff)
      IDLE: begin
        if (pend_ff && master_ff) begin
          nxt_st = SHIFT;
          nxt_pend = 1'b0;
          nxt_scCnt = 4'h0;
          nxt_edgeCnt = 5'h00;
        end
      end
      SHIFT: begin
        if (baudTick) begin
          if (scCnt_ff == cfg.baudScaler) begin
            nxt_scCnt = 4'h0;
            if (edgeCnt_ff == 5'(spi_prescale_pkg::FRAME_EDGES - 1)) begin
              nxt_st = GAP;
            end else begin
              nxt_edgeCnt = edgeCnt_ff + 5'h01;
            end
          end else begin
            nxt_scCnt = scCnt_ff + 4'h1;
          end
        end
      end
      GAP: begin
        if (gapTick) begin
          if (scCnt_ff == cfg.atScaler) begin
            nxt_st = IDLE;
            nxt_scCnt = 4'h0;
          end else begin
            nxt_scCnt = scCnt_ff + 4'h1;
          end
        end
      end
      default: nxt_st = IDLE;
    endcase
    if (!master_ff || !nxt_master) begin
      nxt_st = IDLE;
    end
    if (startWrite) begin
      nxt_pend = 1'b1;
    end
    nxt_pins.sckOe = nxt_master;
    nxt_pins.pcsOe = nxt_master;
    nxt_pins.pcsN = nxt_st != SHIFT;
    nxt_pins.sck = pins_ff.sck;
    if (nxt_st != SHIFT) begin
      nxt_pins.sck = 1'b0;
    end else if (st_ff == SHIFT && baudTick && scCnt_ff == cfg.baudScaler) begin
      nxt_pins.sck = !pins_ff.sck;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= IDLE;
      scCnt_ff <= 4'h0;
      edgeCnt_ff <= 5'h00;
      pend_ff <= 1'b0;
      pins_ff <= '{sck: 1'b0, sckOe: 1'b0, pcsN: 1'b1, pcsOe: 1'b0};
    end else begin
      st_ff <= nxt_st;
      scCnt_ff <= nxt_scCnt;
      edgeCnt_ff <= nxt_edgeCnt;
      pend_ff <= nxt_pend;
      pins_ff <= nxt_pins;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sck = pins_ff.sck;
  assign sckOe = pins_ff.sckOe;
  assign pcsN = pins_ff.pcsN;
  assign pcsOe = pins_ff.pcsOe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [7:0] tickGap_ff;
  logic tickSeen_ff;
  logic [7:0] gapCyc_ff;
  logic sckPrev_ff;
  logic togSeen_ff;
  logic [7:0] halfCyc_ff;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tickGap_ff <= 8'h00;
      tickSeen_ff <= 1'b0;
      gapCyc_ff <= 8'h00;
      sckPrev_ff <= 1'b0;
      togSeen_ff <= 1'b0;
      halfCyc_ff <= 8'h00;
    end else begin
      tickGap_ff <= (baudTick || st_ff != SHIFT) ? 8'h00 : tickGap_ff + 8'h01;
      tickSeen_ff <= st_ff == SHIFT && (tickSeen_ff || baudTick);
      gapCyc_ff <= (st_ff == GAP) ? gapCyc_ff + 8'h01 : 8'h00;
      sckPrev_ff <= sck;
      togSeen_ff <= !pcsN && (togSeen_ff || sck != sckPrev_ff);
      halfCyc_ff <= (pcsN || sck != sckPrev_ff) ? 8'h01 : halfCyc_ff + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_at_decode: assert property (atDiv == {cfg.atPresc, 1'b1})
    else $error("after-transfer prescaler decode wrong");
  a_baud_decode: assert property (cfg.baudPresc != 2'h3 |->
    baudDiv == (cfg.baudPresc == 2'h0 ? 3'h2 : (cfg.baudPresc == 2'h1 ? 3'h3 : 3'h5)))
    else $error("baud prescaler decode wrong");
  a_baud_spacing: assert property (baudTick && tickSeen_ff && $stable(attr_ff) |->
    tickGap_ff == 8'(baudDiv - 3'h1))
    else $error("baud tick spacing differs from prescaler");
  a_gap_length: assert property (st_ff == GAP && nxt_st == IDLE && master_ff && nxt_master |->
    gapCyc_ff == 8'(atDiv) * (8'(cfg.atScaler) + 8'h01))
    else $error("after-transfer gap length wrong");
  a_gap_cs_high: assert property ($rose(st_ff == GAP) |-> pcsN[*3])
    else $error("chip select reasserted inside the gap");
  a_slave_no_frame: assert property (!master_ff && st_ff == IDLE |=> st_ff == IDLE)
    else $error("frame started outside master operation");
  a_slave_no_sck: assert property (!master_ff |-> !sckOe && !sck)
    else $error("serial clock driven as slave");
  a_frame_edges: assert property (st_ff == SHIFT && nxt_st == GAP |->
    edgeCnt_ff == 5'(spi_prescale_pkg::FRAME_EDGES - 1))
    else $error("frame edge count wrong");
  a_apb_ready: assert property (setupPhase |=> pready && pslverr == !$past(mapped))
    else $error("apb answer wrong");
  a_half_period: assert property (!pcsN && sck != sckPrev_ff && togSeen_ff && $stable(attr_ff) |->
    halfCyc_ff == 8'(baudDiv) * (8'(cfg.baudScaler) + 8'h01))
    else $error("serial clock half period differs from prescaler and scaler");
  a_sck_idle_low: assert property (pcsN |-> !sck)
    else $error("serial clock high outside a frame");
  a_oe_master: assert property (sckOe == master_ff && pcsOe == master_ff)
    else $error("pin enables do not follow master mode");
  a_slave_idle: assert property (!master_ff |-> st_ff == IDLE && pcsN)
    else $error("frame or gap active outside master operation");

  c_frame_done: cover property (st_ff == GAP ##[1:300] st_ff == IDLE);
  c_gap_presc7: cover property (st_ff == GAP && cfg.atPresc == 2'h3 && gapTick);
  c_baud_div5: cover property (st_ff == SHIFT && cfg.baudPresc == 2'h2 && baudTick);
  c_start_held: cover property (st_ff == GAP && pend_ff);
  c_abort: cover property (st_ff == SHIFT && !nxt_master);
endmodule

// file: spi_slave_model.sv
// ----------------------------------------
// serial slave: watches select and clock
// ----------------------------------------
module spi_slave_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // serial pins
  input wire logic sck,
  input wire logic sckOe,
  input wire logic pcsN,
  input wire logic pcsOe,
  // measurements
  output logic [15:0] halfLen,
  output logic [15:0] toggles,
  output logic [15:0] gapLen,
  output logic [15:0] frames
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prevSck;
  logic prevCs;
  logic [15:0] cnt;
  logic [15:0] togCnt;
  logic [15:0] gapCnt;
  logic tog;
  // no data lines: this slave only times clock and select
  assign tog = (sck !== prevSck) && sckOe;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prevSck <= 1'b0;
      prevCs <= 1'b1;
      cnt <= '0;
      togCnt <= '0;
      gapCnt <= '0;
      halfLen <= '0;
      toggles <= '0;
      gapLen <= '0;
      frames <= '0;
    end else begin
      prevSck <= sck;
      prevCs <= pcsN;
      cnt <= tog ? 16'h1 : cnt + 16'h1;
      if (tog) begin
        halfLen <= cnt;
      end
      if (pcsOe && !pcsN && prevCs) begin
        togCnt <= 16'(tog);
        gapLen <= gapCnt;
      end else begin
        togCnt <= togCnt + 16'(tog);
      end
      if (pcsOe && pcsN && !prevCs) begin
        toggles <= togCnt + 16'(tog);
        frames <= frames + 16'h1;
        gapCnt <= 16'h1;
      end else if (pcsN) begin
        gapCnt <= gapCnt + 16'h1;
      end
    end
  end
endmodule

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic sck, sckOe, pcsN, pcsOe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] halfLen, toggles, gapLen, frames;
  int numErrors = 0;
  int samplesChecked = 0;
  int cyc = 0;
  // ----------------------------------------
  // design and slave
  // ----------------------------------------
  spi_clock_delay dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck(sck), .sckOe(sckOe), .pcsN(pcsN), .pcsOe(pcsOe));
  spi_slave_model slave (.core_clk(core_clk), .nrst(nrst), .sck(sck), .sckOe(sckOe),
    .pcsN(pcsN), .pcsOe(pcsOe), .halfLen(halfLen), .toggles(toggles), .gapLen(gapLen),
    .frames(frames));
  always #10 core_clk = ~core_clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      numErrors++;
      end_sim();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 50) check("pready", 32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_frames(input logic [15:0] target);
    int k;
    k = 0;
    while (frames < target && k < 4000) begin
      k++;
      @(posedge core_clk);
    end
    check("frames", {16'h0, frames}, {16'h0, target});
  endtask
  function automatic logic [31:0] at_div(input logic [1:0] c);
    return (c == 2'h0) ? 32'h1 : (c == 2'h1) ? 32'h3 : (c == 2'h2) ? 32'h5 : 32'h7;
  endfunction
  function automatic logic [31:0] baud_div(input logic [1:0] c);
    return (c == 2'h0) ? 32'h2 : (c == 2'h1) ? 32'h3 : (c == 2'h2) ? 32'h5 : 32'h7;
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r, v;
    logic e;
    logic [1:0] a, b;
    logic [3:0] s0, s1;
    logic [15:0] f;
    core_clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    r = $urandom(32'h80F2);
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check("pcsN idle", {31'h0, pcsN}, 32'h1);
    apb(1'b0, spi_prescale_pkg::OFS_ATTR, 32'h0, r, e);
    check("attr reset", r, spi_prescale_pkg::ATTR_RESET);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF, r, e);
    check("unmapped write err", {31'h0, e}, 32'h1);
    apb(1'b0, 8'h0C, 32'h0, r, e);
    check("unmapped read", {e, r[30:0]}, 32'h8000_0000);
    apb(1'b0, spi_prescale_pkg::OFS_ATTR, 32'h0, r, e);
    check("attr kept", r, 32'h0);
    apb(1'b1, spi_prescale_pkg::OFS_CTRL, 32'h2, r, e);
    repeat (100) @(posedge core_clk);
    check("slave frames", {16'h0, frames}, 32'h0);
    check("slave pins", {28'h0, sck, sckOe, pcsN, pcsOe}, 32'h2);
    apb(1'b1, spi_prescale_pkg::OFS_CTRL, 32'h1, r, e);
    wait_frames(16'h1);
    for (int i = 0; i < 16; i++) begin
      do begin
        apb(1'b0, spi_prescale_pkg::OFS_STATUS, 32'h0, r, e);
      end while (r[0] !== 1'b0);
      a = 2'(i >> 2);
      b = 2'(i);
      s0 = 4'($urandom % 4);
      s1 = 4'($urandom % 4);
      v = $urandom;
      v[19:16] = {a, b};
      v[7:0] = {s1, s0};
      apb(1'b1, spi_prescale_pkg::OFS_ATTR, v, r, e);
      apb(1'b0, spi_prescale_pkg::OFS_ATTR, 32'h0, r, e);
      check("attr rw", r, v);
      apb(1'b0, spi_prescale_pkg::OFS_STATUS, 32'h0, r, e);
      check("at div", {29'h0, r[14:12]}, at_div(a));
      check("baud div", {29'h0, r[10:8]}, baud_div(b));
      f = frames;
      apb(1'b1, spi_prescale_pkg::OFS_CTRL, 32'h3, r, e);
      check("master oe", {30'h0, sckOe, pcsOe}, 32'h3);
      apb(1'b1, spi_prescale_pkg::OFS_CTRL, 32'h3, r, e);
      wait_frames(f + 16'h2);
      check("half period", {16'h0, halfLen}, baud_div(b) * (s0 + 1));
      check("toggles", {16'h0, toggles}, 32'd16);
      check("gap", {16'h0, gapLen}, at_div(a) * (s1 + 1) + 2);
    end
    do begin
      apb(1'b0, spi_prescale_pkg::OFS_STATUS, 32'h0, r, e);
    end while (r[0] !== 1'b0);
    f = frames;
    apb(1'b1, spi_prescale_pkg::OFS_CTRL, 32'h3, r, e);
    apb(1'b1, spi_prescale_pkg::OFS_CTRL, 32'h0, r, e);
    check("abort pins", {28'h0, sck, sckOe, pcsN, pcsOe}, 32'h2);
    apb(1'b0, spi_prescale_pkg::OFS_STATUS, 32'h0, r, e);
    check("abort status", {28'h0, r[3:0]}, 32'h0);
    repeat (20) @(posedge core_clk);
    check("abort frames", {16'h0, frames}, {16'h0, f});
    end_sim();
  end
endmodule
